/* rtl/echo_canceller_command_control.sv */
// Summary of operation
// - speakerphone word is 1110, 001, line, speaker, loop fields; echoed unchanged.
// - line volume 00 +8 dB, 01 +4 dB, 10 0 dB, 11 mutes microphone.
// - speaker volume 0000 +14 dB down 2 dB steps; 1111 mutes loudspeaker.
// - loop attenuation 0 to -28 dB in 4 dB; 011 up half-duplex; default 010.
// - prefix E012 then 4004 starts train-and-lock; both words echoed.
// - train-and-lock while locked unlocks first so training restarts.
// - prefix E012 then 0004 disables train-and-lock; both words echoed.
// - prefix E012 then C004 forces the locked state at once.
// - while locked, coefficients update only when attenuation beats lock threshold.
// - prefix E014 then signed dB sets lock threshold; default FFF4 (-12 dB).
// - prefix E01B sets unlock threshold, default 0003; amplification above it unlocks.
// - negative dB means attenuation, positive means amplification.
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "echo_cmd_map.svh"

module echo_canceller_command_control (
    // clock and reset
    input  wire  logic                      clk_sys,
    input  wire  logic                      sys_rst,
    // apb slave
    input  wire  echo_cmd_pkg::apb_req_t    apb_in,
    output logic [31:0]                     prdata,
    output logic                            pready,
    output logic                            pslverr,
    // measurement from the canceller datapath
    input  wire  logic [15:0]               meas_atten,
    input  wire  logic                      meas_valid,
    // controls toward the audio path
    output echo_cmd_pkg::audio_ctrl_t       audio_ctrl,
    output logic                            train_enabled,
    output logic                            echo_locked,
    output logic                            coef_update_en,
    output logic [15:0]                     lock_threshold,
    output logic [15:0]                     unlock_threshold,
    // command echo toward the host side
    output logic [15:0]                     status_word,
    output logic                            status_valid,
    output logic                            cmd_strobe
);
    import echo_cmd_pkg::*;

    lock_state_t  lock_state;
    lock_state_t  next_lock_state;
    spkr_param_t  spkr;
    spkr_param_t  next_spkr;
    logic [15:0]  prefix_command_word;
    logic         prefix_pending;
    logic [15:0]  next_prefix_command_word;
    logic         next_prefix_pending;
    logic [15:0]  next_lock_thr;
    logic [15:0]  next_unlock_thr;
    audio_ctrl_t  next_audio;
    logic [31:0]  next_prdata;
    logic         next_coef_update;

    // apb decode
    wire          setup_phase  = apb_in.psel && !apb_in.penable;
    wire          access_done  = apb_in.psel && apb_in.penable && pready;
    wire          wr_done      = access_done && apb_in.pwrite;
    wire          rd_done      = access_done && !apb_in.pwrite;
    wire          hit_cmd      = apb_in.paddr == `REG_CMD;
    wire          hit_status   = apb_in.paddr == `REG_STATUS;
    wire          hit_spkr     = apb_in.paddr == `REG_SPKR;
    wire          hit_lock     = apb_in.paddr == `REG_LOCK_STATE;
    wire          hit_lthr     = apb_in.paddr == `REG_LOCK_THR;
    wire          hit_uthr     = apb_in.paddr == `REG_UNLOCK_THR;
    wire          addr_ok      = hit_cmd || hit_status || hit_spkr
                               || hit_lock || hit_lthr || hit_uthr;
    // cmd is write-only, the rest read-only
    wire          access_ok    = apb_in.pwrite ? hit_cmd : (addr_ok && !hit_cmd);

    // one host command word per cmd write
    wire          cmd_take     = wr_done && hit_cmd;
    wire   [15:0] cmd_word     = apb_in.pwdata[15:0];
    wire          status_rd    = rd_done && hit_status;

    // word classification
    wire          is_spkr_word = !prefix_pending
                               && cmd_word[`SPKR_OP_HI:`SPKR_OP_LO] == `SPKR_OPCODE;
    wire          is_prefix    = !prefix_pending
                               && (cmd_word == `PFX_TRAIN
                                   || cmd_word == `PFX_LOCK_THR
                                   || cmd_word == `PFX_UNLOCK_THR);
    wire          param_take   = cmd_take && prefix_pending;
    wire          train_cmd    = param_take && prefix_command_word == `PFX_TRAIN;
    wire          start_train  = train_cmd && cmd_word == `ARG_TRAIN_START;
    wire          stop_train   = train_cmd && cmd_word == `ARG_TRAIN_OFF;
    wire          force_lock   = train_cmd && cmd_word == `ARG_FORCE_LOCK;
    wire          set_lock_thr = param_take && prefix_command_word == `PFX_LOCK_THR;
    wire          set_unl_thr  = param_take && prefix_command_word == `PFX_UNLOCK_THR;

    // signed dB compares: negative is attenuation, positive amplification
    wire          beats_lock   = meas_valid
                               && $signed(meas_atten) < $signed(lock_threshold);
    wire          over_unlock  = meas_valid
                               && $signed(meas_atten) > $signed(unlock_threshold);

    // prefix tracking: the word after a prefix is its parameter
    always_comb begin
        next_prefix_command_word = prefix_command_word;
        next_prefix_pending      = prefix_pending;
        if (cmd_take) begin
            if (prefix_pending) begin
                next_prefix_pending = 1'b0;
            end else if (is_prefix) begin
                next_prefix_command_word = cmd_word;
                next_prefix_pending      = 1'b1;
            end
        end
    end

    // speakerphone parameter word captured field by field
    always_comb begin
        next_spkr = spkr;
        if (cmd_take && is_spkr_word) begin
            next_spkr.line_vol = cmd_word[`LINE_VOL_HI:`LINE_VOL_LO];
            next_spkr.spk_vol  = cmd_word[`SPK_VOL_HI:`SPK_VOL_LO];
            next_spkr.loop_att = cmd_word[`LOOP_ATT_HI:`LOOP_ATT_LO];
        end
    end

    // each volume field runs through its own instance of the step decoder
    wire   [7:0]  line_gain;
    wire          line_muted;
    wire   [7:0]  spk_gain;
    wire          spk_muted;
    wire   [7:0]  loop_gain;
    wire          loop_half = next_spkr.loop_att >= `HALF_DUPLEX_MIN;

    // line volume, top code mutes the microphone path
    echo_gain_decode #(
        .CODE_W    ($bits(next_spkr.line_vol)),
        .STEP_LOG  (`LINE_STEP_LOG),
        .TOP_DB    (`LINE_GAIN_TOP),
        .HAS_MUTE  (1'b1),
        .MUTE_CODE (`LINE_MUTE_CODE)
    ) line_dec_u (
        .code      (next_spkr.line_vol),
        .gain_db   (line_gain),
        .mute      (line_muted)
    );

    // speaker volume, top code mutes the loudspeaker
    echo_gain_decode #(
        .CODE_W    ($bits(next_spkr.spk_vol)),
        .STEP_LOG  (`SPK_STEP_LOG),
        .TOP_DB    (`SPK_GAIN_TOP),
        .HAS_MUTE  (1'b1),
        .MUTE_CODE (`SPK_MUTE_CODE)
    ) spk_dec_u (
        .code      (next_spkr.spk_vol),
        .gain_db   (spk_gain),
        .mute      (spk_muted)
    );

    // loop attenuation has no mute code
    echo_gain_decode #(
        .CODE_W    ($bits(next_spkr.loop_att)),
        .STEP_LOG  (`LOOP_STEP_LOG),
        .TOP_DB    (`LOOP_GAIN_TOP),
        .HAS_MUTE  (1'b0),
        .MUTE_CODE ('1)
    ) loop_dec_u (
        .code      (next_spkr.loop_att),
        .gain_db   (loop_gain),
        .mute      ()
    );

    assign next_audio = {line_gain, line_muted, spk_gain, spk_muted, loop_gain, loop_half};

    // thresholds are plain signed dB words
    always_comb begin
        next_lock_thr   = lock_threshold;
        next_unlock_thr = unlock_threshold;
        if (set_lock_thr) begin
            next_lock_thr = cmd_word;
        end
        if (set_unl_thr) begin
            next_unlock_thr = cmd_word;
        end
    end

    // train-and-lock state; host commands outrank measurements
    always_comb begin
        next_lock_state = lock_state;
        if (stop_train) begin
            next_lock_state = LOCK_OFF;
        end else if (force_lock) begin
            next_lock_state = LOCK_HELD;
        end else if (start_train) begin
            // also drops an existing lock so training starts afresh
            next_lock_state = LOCK_TRAINING;
        end else begin
            case (lock_state)
                LOCK_OFF: begin
                    next_lock_state = LOCK_OFF;
                end
                LOCK_TRAINING: begin
                    if (beats_lock) begin
                        next_lock_state = LOCK_HELD;
                    end
                end
                LOCK_HELD: begin
                    // a forced lock with huge thresholds never leaves here
                    if (over_unlock) begin
                        next_lock_state = LOCK_TRAINING;
                    end
                end
                default: begin
                    next_lock_state = LOCK_OFF;
                end
            endcase
        end
    end

    // coefficient update gate
    always_comb begin
        case (lock_state)
            LOCK_HELD: begin
                next_coef_update = beats_lock;
            end
            default: begin
                next_coef_update = 1'b1;
            end
        endcase
    end

    // read data mux, captured in the setup phase
    always_comb begin
        next_prdata = 32'h0000_0000;
        if (hit_status) begin
            next_prdata = {15'h0000, status_valid, status_word};
        end else if (hit_spkr) begin
            next_prdata = {23'h00_0000, spkr};
        end else if (hit_lock) begin
            next_prdata = {27'h000_0000, prefix_pending, coef_update_en,
                           echo_locked, train_enabled, lock_state == LOCK_HELD};
        end else if (hit_lthr) begin
            next_prdata = {16'h0000, lock_threshold};
        end else if (hit_uthr) begin
            next_prdata = {16'h0000, unlock_threshold};
        end
    end

    // apb handshake: zero wait states
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup_phase;
            pslverr <= setup_phase && !access_ok;
            prdata  <= setup_phase ? next_prdata : 32'h0000_0000;
        end
    end

    // every accepted word is echoed as status
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            status_word  <= 16'h0000;
            status_valid <= 1'b0;
            cmd_strobe   <= 1'b0;
        end else begin
            cmd_strobe <= cmd_take;
            if (cmd_take) begin
                status_word <= cmd_word;
            end
            // a new echo wins over the read that clears the old one
            status_valid <= cmd_take || (status_valid && !status_rd);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            prefix_command_word <= 16'h0000;
            prefix_pending      <= 1'b0;
        end else begin
            prefix_command_word <= next_prefix_command_word;
            prefix_pending      <= next_prefix_pending;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            spkr.line_vol            <= `DEF_LINE_VOL;
            spkr.spk_vol             <= `DEF_SPK_VOL;
            spkr.loop_att            <= `DEF_LOOP_ATT;
            audio_ctrl.line_gain_db  <= `LINE_GAIN_TOP - {4'h0, `DEF_LINE_VOL, 2'h0};
            audio_ctrl.line_mute     <= 1'b0;
            audio_ctrl.spk_gain_db   <= `SPK_GAIN_TOP - {3'h0, `DEF_SPK_VOL, 1'h0};
            audio_ctrl.spk_mute      <= 1'b0;
            audio_ctrl.loop_atten_db <= `LOOP_GAIN_TOP - {3'h0, `DEF_LOOP_ATT, 2'h0};
            audio_ctrl.half_duplex   <= 1'b0;
        end else begin
            spkr       <= next_spkr;
            audio_ctrl <= next_audio;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            lock_threshold   <= `DEF_LOCK_THR;
            unlock_threshold <= `DEF_UNLOCK_THR;
        end else begin
            lock_threshold   <= next_lock_thr;
            unlock_threshold <= next_unlock_thr;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            lock_state     <= LOCK_OFF;
            train_enabled  <= 1'b0;
            echo_locked    <= 1'b0;
            coef_update_en <= 1'b1;
        end else begin
            lock_state     <= next_lock_state;
            train_enabled  <= next_lock_state != LOCK_OFF;
            echo_locked    <= next_lock_state == LOCK_HELD;
            coef_update_en <= next_coef_update;
        end
    end

endmodule : echo_canceller_command_control

// one volume code to a signed dB gain; a muted path reports no gain, not a stale step
module echo_gain_decode #(
    parameter int                CODE_W    = 2,
    parameter int                STEP_LOG  = 2,
    parameter logic [7:0]        TOP_DB    = 8'h08,
    parameter bit                HAS_MUTE  = 1'b1,
    parameter logic [CODE_W-1:0] MUTE_CODE = '1
) (
    // field code
    input  wire logic [CODE_W-1:0] code,
    // decoded level
    output logic [7:0]             gain_db,
    output logic                   mute
);
    wire   [7:0]  step_db = 8'(code) << STEP_LOG;
    wire   [7:0]  raw_db  = TOP_DB - step_db;

    assign mute    = HAS_MUTE && code == MUTE_CODE;
    assign gain_db = mute ? 8'h00 : raw_db;

endmodule : echo_gain_decode
`default_nettype wire

/* rtl/echo_cmd_map.svh */
`ifndef ECHO_CMD_MAP_SVH
`define ECHO_CMD_MAP_SVH

// register byte offsets on the apb side
`define ADDR_W             8
`define REG_CMD            8'h00
`define REG_STATUS         8'h04
`define REG_SPKR           8'h08
`define REG_LOCK_STATE     8'h0c
`define REG_LOCK_THR       8'h10
`define REG_UNLOCK_THR     8'h14

// status register layout
`define STATUS_VALID_BIT   16

// speakerphone parameter word
`define SPKR_OP_HI         15
`define SPKR_OP_LO         9
`define SPKR_OPCODE        7'h71
`define LINE_VOL_HI        8
`define LINE_VOL_LO        7
`define SPK_VOL_HI         6
`define SPK_VOL_LO         3
`define LOOP_ATT_HI        2
`define LOOP_ATT_LO        0

// prefix and parameter words
`define PFX_TRAIN          16'he012
`define PFX_LOCK_THR       16'he014
`define PFX_UNLOCK_THR     16'he01b
`define ARG_TRAIN_START    16'h4004
`define ARG_TRAIN_OFF      16'h0004
`define ARG_FORCE_LOCK     16'hc004

// reset values
`define DEF_LOCK_THR       16'hfff4
`define DEF_UNLOCK_THR     16'h0003
`define DEF_LINE_VOL       2'h2
`define DEF_SPK_VOL        4'h7
`define DEF_LOOP_ATT       3'h2

// field decoding
`define LINE_MUTE_CODE     2'h3
`define SPK_MUTE_CODE      4'hf
`define HALF_DUPLEX_MIN    3'h3
`define LINE_GAIN_TOP      8'h08
`define SPK_GAIN_TOP       8'h0e
`define LOOP_GAIN_TOP      8'h00
`define LINE_STEP_LOG      2
`define SPK_STEP_LOG       1
`define LOOP_STEP_LOG      2

`endif

/* rtl/echo_cmd_pkg.sv */
package echo_cmd_pkg;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef enum logic [1:0] {
        LOCK_OFF,
        LOCK_TRAINING,
        LOCK_HELD
    } lock_state_t;

    typedef struct packed {
        logic [1:0] line_vol;
        logic [3:0] spk_vol;
        logic [2:0] loop_att;
    } spkr_param_t;

    typedef struct packed {
        logic [7:0] line_gain_db;
        logic       line_mute;
        logic [7:0] spk_gain_db;
        logic       spk_mute;
        logic [7:0] loop_atten_db;
        logic       half_duplex;
    } audio_ctrl_t;

endpackage : echo_cmd_pkg

/* testbench/echo_cmd_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module echo_cmd_checker (
    // clock and reset
    input wire logic                      clk_sys,
    input wire logic                      sys_rst,
    // apb
    input wire echo_cmd_pkg::apb_req_t    apb_in,
    input wire logic [31:0]               prdata,
    input wire logic                      pready,
    input wire logic                      pslverr,
    // datapath and controls
    input wire logic [15:0]               meas_atten,
    input wire logic                      meas_valid,
    input wire echo_cmd_pkg::audio_ctrl_t audio_ctrl,
    input wire logic                      train_enabled,
    input wire logic                      echo_locked,
    input wire logic                      coef_update_en,
    input wire logic [15:0]               lock_threshold,
    input wire logic [15:0]               unlock_threshold,
    // command echo
    input wire logic [15:0]               status_word,
    input wire logic                      status_valid,
    input wire logic                      cmd_strobe
);
    import echo_cmd_pkg::*;
    logic        pend;
    logic [15:0] last;
    wire         wr_cmd = apb_in.psel && apb_in.penable && pready && apb_in.pwrite
                          && apb_in.paddr == 8'h00;
    wire  [15:0] d      = apb_in.pwdata[15:0];
    wire         spk_w  = wr_cmd && !pend && d[15:9] == 7'h71;
    wire         par_w  = wr_cmd && pend && last == 16'he012;
    wire  [1:0]  lv     = last[8:7];
    wire  [3:0]  sv     = last[6:3];
    wire  [2:0]  la     = last[2:0];
    // a word right after a prefix is its parameter, even another prefix
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pend <= 1'b0;
        end else if (wr_cmd) begin
            pend <= !pend && (d == 16'he012 || d == 16'he014 || d == 16'he01b);
        end
    end
    always_ff @(posedge clk_sys) begin
        if (wr_cmd) begin
            last <= d;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    property p_echo; wr_cmd |=> status_word == $past(d) && status_valid && cmd_strobe; endproperty
    a_echo: assert property (p_echo) else $error("command word not echoed");
    property p_strobe; !wr_cmd |=> !cmd_strobe; endproperty
    a_strobe: assert property (p_strobe) else $error("command strobe held too long");
    property p_line; spk_w |=> audio_ctrl.line_mute == (lv == 2'h3) && audio_ctrl.line_gain_db
        == ((lv == 2'h3) ? 8'h00 : 8'h08 - {4'h0, lv, 2'h0}); endproperty
    a_line: assert property (p_line) else $error("line volume decode wrong");
    property p_spk; spk_w |=> audio_ctrl.spk_mute == (sv == 4'hf) && audio_ctrl.spk_gain_db
        == ((sv == 4'hf) ? 8'h00 : 8'h0e - {3'h0, sv, 1'b0}); endproperty
    a_spk: assert property (p_spk) else $error("speaker volume decode wrong");
    property p_loop; spk_w |=> audio_ctrl.half_duplex == (la >= 3'h3)
        && audio_ctrl.loop_atten_db == 8'h00 - {3'h0, la, 2'h0}; endproperty
    a_loop: assert property (p_loop) else $error("loop attenuation decode wrong");
    property p_train; par_w && d == 16'h4004 |=> train_enabled && !echo_locked; endproperty
    a_train: assert property (p_train) else $error("training not started");
    property p_off; par_w && d == 16'h0004 |=> !train_enabled && !echo_locked; endproperty
    a_off: assert property (p_off) else $error("feature not disabled");
    property p_force; par_w && d == 16'hc004 |=> echo_locked && train_enabled; endproperty
    a_force: assert property (p_force) else $error("forced lock missing");
    property p_coef; echo_locked && $past(echo_locked) |-> coef_update_en
        == $past(meas_valid && $signed(meas_atten) < $signed(lock_threshold)); endproperty
    a_coef: assert property (p_coef) else $error("coefficient gating wrong");
    property p_unlock; echo_locked && meas_valid && !wr_cmd
        && $signed(meas_atten) > $signed(unlock_threshold) |=> !echo_locked && train_enabled;
    endproperty
    a_unlock: assert property (p_unlock) else $error("no unlock on amplification");
    c_spk: cover property (spk_w);
    c_lock: cover property (echo_locked && meas_valid);
    c_unlock: cover property (echo_locked ##1 (!echo_locked && train_enabled));
endmodule : echo_cmd_checker
`default_nettype wire

/* testbench/echo_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module echo_host_model (
    // clock
    input  wire logic              clk_sys,
    // apb master side
    output echo_cmd_pkg::apb_req_t apb_in,
    input  wire logic [31:0]       prdata,
    input  wire logic              pready,
    input  wire logic              pslverr
);
    import echo_cmd_pkg::*;
    initial apb_in = '0;
    // idle cycles model a slow host; each word completes before the next starts
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        input int idle, output logic [31:0] rd, output logic err);
        repeat (idle + 1) @(posedge clk_sys);
        apb_in <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        @(posedge clk_sys);
        apb_in.penable <= 1'b1;
        // answer taken at the completing edge; only the bench watchdog ends a hang
        @(posedge clk_sys);
        while (pready !== 1'b1) begin
            @(posedge clk_sys);
        end
        rd = prdata;
        err = pslverr;
        // released lines carry junk, never the last request
        apb_in <= '{psel: 1'b0, penable: 1'b0, pwrite: ~wr, paddr: ~a, pwdata: ~wd};
    endtask : xfer
endmodule : echo_host_model
`default_nettype wire

/* testbench/echo_canceller_command_control_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module echo_canceller_command_control_tb_top;
    import echo_cmd_pkg::*;
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic        meas_valid = 1'b0;
    logic [15:0] meas_atten = 16'h0000;
    apb_req_t    apb_in;
    audio_ctrl_t audio_ctrl;
    logic [31:0] prdata, v;
    logic        pready, pslverr, e, train_enabled, echo_locked, coef_update_en;
    logic [15:0] lock_threshold, unlock_threshold, status_word;
    logic        status_valid, cmd_strobe;
    int          n_mismatch = 0;
    int          num_checks = 0;

    always #20 clk_sys = ~clk_sys;

    echo_host_model host_u (.clk_sys(clk_sys), .apb_in(apb_in), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    echo_canceller_command_control dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .apb_in(apb_in), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .meas_atten(meas_atten), .meas_valid(meas_valid), .audio_ctrl(audio_ctrl),
        .train_enabled(train_enabled), .echo_locked(echo_locked),
        .coef_update_en(coef_update_en), .lock_threshold(lock_threshold),
        .unlock_threshold(unlock_threshold), .status_word(status_word),
        .status_valid(status_valid), .cmd_strobe(cmd_strobe));

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // upper data bits set on purpose: only the low half is a command
    task automatic cmd(input logic [15:0] w);
        host_u.xfer(1'b1, 8'h00, {16'hffff, w}, 0, v, e);
        host_u.xfer(1'b0, 8'h04, 32'h0, 2, v, e);
        chk("status", v, {15'h0, 1'b1, w});
    endtask : cmd
    // state settles on the sample edge; one spare edge added
    task automatic meas(input logic vld, input logic [15:0] m);
        @(posedge clk_sys);
        meas_valid <= vld;
        meas_atten <= m;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask : meas
    function automatic logic [31:0] exp_audio(input logic [1:0] l, input logic [3:0] s,
                                              input logic [2:0] a);
        return {5'h0, ((l == 2'h3) ? 8'h00 : 8'h08 - {4'h0, l, 2'h0}), l == 2'h3,
                ((s == 4'hf) ? 8'h00 : 8'h0e - {3'h0, s, 1'b0}), s == 4'hf,
                8'h00 - {3'h0, a, 2'h0}, a >= 3'h3};
    endfunction : exp_audio
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim

    initial begin
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        #1;
        chk("audio", 32'(audio_ctrl), exp_audio(2'h2, 4'h7, 3'h2));
        chk("thr", {lock_threshold, unlock_threshold}, 32'hfff40003);
        chk("state", {train_enabled, echo_locked, coef_update_en}, 3'b001);
        $display("test defaults finished");
        // bench host: playback and record count as running already
        for (int i = 0; i < 16; i++) begin
            cmd({7'h71, 2'(i), 4'(i), 3'(i)});
            chk("audio", 32'(audio_ctrl), exp_audio(2'(i), 4'(i), 3'(i)));
        end
        host_u.xfer(1'b0, 8'h08, 32'h0, 0, v, e);
        chk("spkr", v, 32'h1ff);
        $display("test speakerphone finished");
        cmd(16'he014);
        cmd(16'hfff0);
        cmd(16'he01b);
        cmd(16'h0005);
        host_u.xfer(1'b0, 8'h10, 32'h0, 1, v, e);
        chk("lock thr", v, 32'hfff0);
        chk("unlock thr", unlock_threshold, 16'h0005);
        host_u.xfer(1'b0, 8'h14, 32'h0, 0, v, e);
        chk("unlock reg", v, 32'h0005);
        cmd(16'he012);
        cmd(16'h4004);
        chk("train", {train_enabled, echo_locked}, 2'b10);
        meas(1'b1, 16'hfff0);
        chk("at lock thr", echo_locked, 1'b0);
        meas(1'b1, 16'hffef);
        chk("lock", {echo_locked, coef_update_en}, 2'b11);
        meas(1'b1, 16'h0005);
        chk("frozen", {echo_locked, coef_update_en}, 2'b10);
        meas(1'b1, 16'h0006);
        chk("unlock", {train_enabled, echo_locked}, 2'b10);
        meas(1'b0, 16'h0006);
        $display("test train and lock finished");
        cmd(16'he012);
        cmd(16'hc004);
        chk("forced", {echo_locked, coef_update_en}, 2'b10);
        // no measurement runs while locked: the echo path stays fixed
        host_u.xfer(1'b0, 8'h0c, 32'h0, 0, v, e);
        chk("lock reg", v, 32'h0007);
        cmd(16'he012);
        cmd(16'h4004);
        chk("retrain", {train_enabled, echo_locked}, 2'b10);
        cmd(16'he012);
        cmd(16'h0004);
        chk("off", {train_enabled, echo_locked, coef_update_en}, 3'b001);
        cmd(16'he012);
        cmd(16'h1234);
        chk("unknown", {train_enabled, echo_locked}, 2'b00);
        $display("test commands finished");
        host_u.xfer(1'b0, 8'h00, 32'h0, 0, v, e);
        chk("cmd read err", {e, v[30:0]}, 32'h80000000);
        host_u.xfer(1'b1, 8'h18, 32'h5, 0, v, e);
        chk("unmapped err", e, 1'b1);
        host_u.xfer(1'b0, 8'h04, 32'h0, 0, v, e);
        chk("status clr", v, 32'h1234);
        $display("test access errors finished");
        end_sim();
    end

    initial begin
        repeat (6000) @(posedge clk_sys);
        n_mismatch++;
        end_sim();
    end
endmodule : echo_canceller_command_control_tb_top

bind echo_canceller_command_control echo_cmd_checker chk_u (.*);
`default_nettype wire
